// [design/fci_host.sv]
// Purpose: Host that drives a 64K x 8 parallel flash through its pins.
// Assumes: Single 100 MHz clock; the host times program and erase pulses in clock cycles.
// Notes: One request at a time; the flash data bus is sampled through two flops.
//
// Contract
// - Command 00H selects array read for later read cycles.
// - After 90H, address 00 reads maker code and 01 reads part code.
// - Whole-array erase starts only after two consecutive 20H writes.
// - A0H with an address starts erase verify; next read returns verify data.
// - Program is 40H then a write carrying target address and data.
// - C0H after programming starts verify; next read returns that byte.
// - Two consecutive FFH writes reset the flash command state.
// - Host holds chip select low, output drive high, strobe low, supply high.
// - Host waits 6 us after a program or erase write before reading.
// - Host allows 16 us per attempt and at most 25 attempts per byte.
// - Host programs every byte to 00H before erasing.
// - After each erase pulse the host verifies bytes from the failing address onward, re-erasing on failure.
`timescale 1ns/10ps
module fci_host #(
  parameter int ERASE_CYC = fci_pkg::ERASE_CYC,
  parameter int DEPTH = 65536,
  parameter int MAX_ERASE = fci_pkg::MAX_ERASE
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reqValid,
  output logic reqReady,
  input wire fci_pkg::fci_op_t reqOp,
  input wire logic [fci_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [fci_pkg::DATA_W-1:0] reqData,
  output logic rspValid,
  output logic rspFail,
  output logic [fci_pkg::DATA_W-1:0] rspData,
  output logic chipSelN,
  output logic outDriveN,
  output logic writeStrobeN,
  output logic programSupplyHigh,
  output logic addressBitNineHv,
  output logic [fci_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fci_pkg::DATA_W-1:0] dqIn,
  output logic [fci_pkg::DATA_W-1:0] dqOut,
  output logic dqOeN
);

  localparam int CW = fci_pkg::CNT_W;
  localparam int AW = fci_pkg::ADDR_W;
  localparam int DW = fci_pkg::DATA_W;
  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

  // ----------------------------------------------------------------
  // Data bus synchroniser
  // ----------------------------------------------------------------
  // The data pins change asynchronously to clk, so reads wait two extra cycles.
  logic [DW-1:0] dqMeta_q;
  logic [DW-1:0] dqSync_q;
  always_ff @(posedge clk) begin
    dqMeta_q <= dqIn;
    dqSync_q <= dqMeta_q;
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  fci_pkg::fci_state_t state_q;
  fci_pkg::fci_phase_t phase_q;
  fci_pkg::fci_op_t op_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] wait_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [DW-1:0] rdData_q;
  logic [AW-1:0] scan_q;
  logic [4:0] tries_q;
  logic [9:0] eraseTries_q;
  logic preDone_q;
  logic [DW-1:0] lastWr_q;
  logic [DW-1:0] prevWr_q;

  fci_pkg::fci_act_t actKind;
  fci_pkg::fci_phase_t actNext;
  logic [DW-1:0] actData;
  logic [AW-1:0] actAddr;
  logic [CW-1:0] actWait;
  logic actFail;

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction

  assign reqReady = (state_q == fci_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // Phase decisions
  // ----------------------------------------------------------------
  always_comb begin
    actKind = fci_pkg::A_JUMP;
    actNext = fci_pkg::PH_FINISH;
    actData = fci_pkg::CMD_READ;
    actAddr = '0;
    actWait = '0;
    actFail = 1'b0;
    unique case (phase_q)
      fci_pkg::PH_VPP_ON: begin
        unique case (op_q)
          fci_pkg::OP_READ: actNext = fci_pkg::PH_SETREAD;
          fci_pkg::OP_SIG: actNext = fci_pkg::PH_SIGCMD;
          fci_pkg::OP_SIG_HV: actNext = fci_pkg::PH_HVREAD;
          fci_pkg::OP_PROGRAM: actNext = fci_pkg::PH_PGM_CMD;
          fci_pkg::OP_ERASE: actNext = fci_pkg::PH_PGM_CMD;
          fci_pkg::OP_RESET: actNext = fci_pkg::PH_RST1;
          default: actNext = fci_pkg::PH_FAIL;
        endcase
      end
      fci_pkg::PH_SETREAD: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_READ;
        actNext = fci_pkg::PH_READ;
      end
      fci_pkg::PH_READ: begin
        actKind = fci_pkg::A_RD;
        actAddr = addr_q;
      end
      fci_pkg::PH_SIGCMD: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_SIG;
        actNext = fci_pkg::PH_SIGREAD;
      end
      fci_pkg::PH_SIGREAD, fci_pkg::PH_HVREAD: begin
        actKind = fci_pkg::A_RD;
        actAddr = {{(AW-1){1'b0}}, addr_q[0]};
      end
      fci_pkg::PH_PGM_CMD: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_PGM;
        actNext = fci_pkg::PH_PGM_DATA;
      end
      fci_pkg::PH_PGM_DATA: begin
        actKind = fci_pkg::A_WR;
        actAddr = (op_q == fci_pkg::OP_ERASE) ? scan_q : addr_q;
        actData = (op_q == fci_pkg::OP_ERASE) ? fci_pkg::BYTE_PREPGM : data_q;
        actWait = cyc(fci_pkg::PROG_CYC);
        actNext = fci_pkg::PH_PV_CMD;
      end
      fci_pkg::PH_PV_CMD: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_PV;
        actWait = cyc(fci_pkg::REC_CYC);
        actNext = fci_pkg::PH_PV_READ;
      end
      fci_pkg::PH_PV_READ: begin
        actKind = fci_pkg::A_RD;
        actNext = fci_pkg::PH_PV_CHECK;
      end
      fci_pkg::PH_PV_CHECK: begin
        if (rdData_q == ((op_q == fci_pkg::OP_ERASE) ? fci_pkg::BYTE_PREPGM : data_q)) begin
          actNext = (op_q == fci_pkg::OP_ERASE) ? fci_pkg::PH_PRE_NEXT : fci_pkg::PH_FINISH;
        end else if (tries_q == 5'(fci_pkg::MAX_TRIES)) begin
          actNext = fci_pkg::PH_FAIL;
        end else begin
          actNext = fci_pkg::PH_PGM_CMD;
        end
      end
      fci_pkg::PH_PRE_NEXT: begin
        actNext = (scan_q == LAST_ADDR) ? fci_pkg::PH_ER_CMD1 : fci_pkg::PH_PGM_CMD;
      end
      fci_pkg::PH_ER_CMD1: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_ERASE;
        actNext = fci_pkg::PH_ER_CMD2;
      end
      fci_pkg::PH_ER_CMD2: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_ERASE;
        actWait = cyc(ERASE_CYC);
        actNext = fci_pkg::PH_EV_CMD;
      end
      fci_pkg::PH_EV_CMD: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_EV;
        actAddr = scan_q;
        actWait = cyc(fci_pkg::REC_CYC);
        actNext = fci_pkg::PH_EV_READ;
      end
      fci_pkg::PH_EV_READ: begin
        actKind = fci_pkg::A_RD;
        actAddr = scan_q;
        actNext = fci_pkg::PH_EV_CHECK;
      end
      fci_pkg::PH_EV_CHECK: begin
        if (rdData_q == fci_pkg::BYTE_ERASED) begin
          actNext = (scan_q == LAST_ADDR) ? fci_pkg::PH_FINISH : fci_pkg::PH_EV_CMD;
        end else if (eraseTries_q == 10'(MAX_ERASE)) begin
          actNext = fci_pkg::PH_FAIL;
        end else begin
          actNext = fci_pkg::PH_ER_CMD1;
        end
      end
      fci_pkg::PH_RST1: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_RESET;
        actNext = fci_pkg::PH_RST2;
      end
      fci_pkg::PH_RST2: begin
        actKind = fci_pkg::A_WR;
        actData = fci_pkg::CMD_RESET;
      end
      fci_pkg::PH_FINISH: actKind = fci_pkg::A_DONE;
      fci_pkg::PH_FAIL: begin
        actKind = fci_pkg::A_DONE;
        actFail = 1'b1;
      end
      default: actKind = fci_pkg::A_DONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus cycles and pins
  // ----------------------------------------------------------------
  // Write strobe low with chip select low and output drive high keeps the flash
  // in its input mode; the idle state leaves every pin released (standby).
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= fci_pkg::ST_IDLE;
      phase_q <= fci_pkg::PH_VPP_ON;
      op_q <= fci_pkg::OP_READ;
      cnt_q <= '0;
      wait_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      rdData_q <= '0;
      chipSelN <= 1'b1;
      outDriveN <= 1'b1;
      writeStrobeN <= 1'b1;
      programSupplyHigh <= 1'b0;
      addressBitNineHv <= 1'b0;
      flashAddr <= '0;
      dqOut <= '0;
      dqOeN <= 1'b1;
    end else begin
      unique case (state_q)
        fci_pkg::ST_IDLE: begin
          if (reqValid) begin
            op_q <= reqOp;
            addr_q <= reqAddr;
            data_q <= reqData;
            phase_q <= fci_pkg::PH_VPP_ON;
            programSupplyHigh <= (reqOp != fci_pkg::OP_SIG_HV);
            addressBitNineHv <= (reqOp == fci_pkg::OP_SIG_HV);
            cnt_q <= cyc(fci_pkg::VPP_CYC);
            state_q <= fci_pkg::ST_DLY;
          end
        end
        fci_pkg::ST_WR: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            writeStrobeN <= 1'b1;
            cnt_q <= cyc(fci_pkg::WPH_CYC - 1);
            state_q <= fci_pkg::ST_WRH;
          end
        end
        fci_pkg::ST_WRH: begin
          cnt_q <= cnt_q - 1'b1;
          chipSelN <= 1'b1;
          dqOeN <= 1'b1;
          if (cnt_q == '0) begin
            cnt_q <= wait_q;
            state_q <= fci_pkg::ST_DLY;
          end
        end
        fci_pkg::ST_RD: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            rdData_q <= dqSync_q;
            chipSelN <= 1'b1;
            outDriveN <= 1'b1;
            state_q <= fci_pkg::ST_NEXT;
          end
        end
        fci_pkg::ST_DLY: begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == '0) begin
            state_q <= fci_pkg::ST_NEXT;
          end
        end
        fci_pkg::ST_NEXT: begin
          phase_q <= actNext;
          wait_q <= actWait;
          unique case (actKind)
            fci_pkg::A_WR: begin
              flashAddr <= actAddr;
              dqOut <= actData;
              dqOeN <= 1'b0;
              chipSelN <= 1'b0;
              writeStrobeN <= 1'b0;
              cnt_q <= cyc(fci_pkg::WP_CYC - 1);
              state_q <= fci_pkg::ST_WR;
            end
            fci_pkg::A_RD: begin
              flashAddr <= actAddr;
              chipSelN <= 1'b0;
              outDriveN <= 1'b0;
              cnt_q <= cyc(fci_pkg::ACC_CYC - 1);
              state_q <= fci_pkg::ST_RD;
            end
            fci_pkg::A_JUMP: state_q <= fci_pkg::ST_NEXT;
            fci_pkg::A_DONE: begin
              programSupplyHigh <= 1'b0;
              addressBitNineHv <= 1'b0;
              state_q <= fci_pkg::ST_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Loop counters and write history
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scan_q <= '0;
      tries_q <= '0;
      eraseTries_q <= '0;
      preDone_q <= 1'b0;
      lastWr_q <= '0;
      prevWr_q <= '0;
    end else if (state_q == fci_pkg::ST_IDLE && reqValid) begin
      scan_q <= '0;
      tries_q <= 5'h1;
      eraseTries_q <= 10'h1;
      preDone_q <= 1'b0;
    end else if (state_q == fci_pkg::ST_NEXT) begin
      if (actKind == fci_pkg::A_WR) begin
        prevWr_q <= lastWr_q;
        lastWr_q <= actData;
      end
      if (phase_q == fci_pkg::PH_PV_CHECK && actNext == fci_pkg::PH_PGM_CMD) begin
        tries_q <= tries_q + 5'h1;
      end
      if (phase_q == fci_pkg::PH_PRE_NEXT) begin
        tries_q <= 5'h1;
        scan_q <= (scan_q == LAST_ADDR) ? '0 : scan_q + 1'b1;
        preDone_q <= (scan_q == LAST_ADDR);
      end
      if (phase_q == fci_pkg::PH_EV_CHECK) begin
        if (actNext == fci_pkg::PH_EV_CMD) begin
          scan_q <= scan_q + 1'b1;
        end else if (actNext == fci_pkg::PH_ER_CMD1) begin
          eraseTries_q <= eraseTries_q + 10'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rspValid <= 1'b0;
      rspFail <= 1'b0;
      rspData <= '0;
    end else begin
      rspValid <= (state_q == fci_pkg::ST_NEXT) && (actKind == fci_pkg::A_DONE);
      if (state_q == fci_pkg::ST_NEXT && actKind == fci_pkg::A_DONE) begin
        rspFail <= actFail;
        rspData <= rdData_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CW-1:0] sinceWe_q;
  always_ff @(posedge clk) begin
    if (!nrst || $fell(writeStrobeN)) begin
      sinceWe_q <= '0;
    end else if (sinceWe_q != '1) begin
      sinceWe_q <= sinceWe_q + 1'b1;
    end
  end

  chk_write_levels: assert property (@(posedge clk) disable iff (!nrst)
    !writeStrobeN |-> !chipSelN && outDriveN && programSupplyHigh && !dqOeN)
    else $error("write cycle pin levels wrong");
  chk_write_recovery: assert property (@(posedge clk) disable iff (!nrst)
    $fell(outDriveN) && (lastWr_q == fci_pkg::CMD_PV || lastWr_q == fci_pkg::CMD_EV)
      |-> sinceWe_q >= cyc(fci_pkg::REC_CYC + fci_pkg::WP_CYC))
    else $error("read started before write recovery");
  chk_try_limit: assert property (@(posedge clk) disable iff (!nrst)
    rspValid && rspFail && op_q == fci_pkg::OP_PROGRAM |-> tries_q == 5'(fci_pkg::MAX_TRIES))
    else $error("program gave up at wrong attempt count");
  chk_pre_program: assert property (@(posedge clk) disable iff (!nrst)
    state_q == fci_pkg::ST_WR && phase_q == fci_pkg::PH_ER_CMD2 |-> preDone_q)
    else $error("erase issued before pre-programming");
  chk_erase_pair: assert property (@(posedge clk) disable iff (!nrst)
    state_q == fci_pkg::ST_WR && phase_q == fci_pkg::PH_EV_CMD && lastWr_q == fci_pkg::CMD_ERASE
      |-> prevWr_q == fci_pkg::CMD_ERASE)
    else $error("erase pulse without two erase commands");
  chk_program_pair: assert property (@(posedge clk) disable iff (!nrst)
    state_q == fci_pkg::ST_WR && phase_q == fci_pkg::PH_PV_CMD |-> prevWr_q == fci_pkg::CMD_PGM)
    else $error("program data not preceded by program command");
  chk_verify_prog: assert property (@(posedge clk) disable iff (!nrst)
    state_q == fci_pkg::ST_WR && phase_q == fci_pkg::PH_PV_READ && op_q == fci_pkg::OP_PROGRAM
      |-> lastWr_q == fci_pkg::CMD_PV && prevWr_q == data_q)
    else $error("program verify not after programmed byte");
  chk_reset_pair: assert property (@(posedge clk) disable iff (!nrst)
    rspValid && op_q == fci_pkg::OP_RESET |-> lastWr_q == fci_pkg::CMD_RESET
      && prevWr_q == fci_pkg::CMD_RESET)
    else $error("reset without two reset commands");
  chk_read_mode: assert property (@(posedge clk) disable iff (!nrst)
    $fell(outDriveN) && op_q == fci_pkg::OP_READ |-> lastWr_q == fci_pkg::CMD_READ)
    else $error("array read without read command");
  chk_sig_addr: assert property (@(posedge clk) disable iff (!nrst)
    $fell(outDriveN) && (op_q == fci_pkg::OP_SIG || op_q == fci_pkg::OP_SIG_HV)
      |-> flashAddr[AW-1:1] == '0)
    else $error("signature read at wrong address");
  chk_verify_addr: assert property (@(posedge clk) disable iff (!nrst)
    $fell(outDriveN) && op_q == fci_pkg::OP_ERASE && lastWr_q == fci_pkg::CMD_EV
      |-> flashAddr == scan_q)
    else $error("erase verify read at wrong address");

endmodule

// [design/fci_pkg.sv]
// Purpose: Shared constants and types for the parallel flash command host.
// Assumes: A 100 MHz system clock and a 64K x 8 flash on the far side of the pins.
// Notes: Cycle counts round each minimum time up to whole clocks.
package fci_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_WP_NS = 40;
  localparam int T_WPH_NS = 20;
  localparam int T_ACC_NS = 150;
  localparam int T_VPP_NS = 100;
  localparam int T_PROG_US = 10;
  localparam int T_REC_US = 6;
  localparam int T_TRY_US = 16;
  localparam real T_ERASE_MS = 9.5;
  localparam int SYNC_STAGES = 2;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int VPP_CYC = (T_VPP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_CYC = (T_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REC_CYC = (T_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TRY_CYC = (T_TRY_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = int'($ceil(T_ERASE_MS * 1000000.0 / CLK_NS));

  // ----------------------------------------------------------------
  // Geometry and limits
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int CNT_W = 20;
  localparam int MAX_TRIES = 25;
  localparam int MAX_ERASE = 1000;

  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_EV = 8'ha0;
  localparam logic [7:0] CMD_PGM = 8'h40;
  localparam logic [7:0] CMD_PV = 8'hc0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] BYTE_ERASED = 8'hff;
  localparam logic [7:0] BYTE_PREPGM = 8'h00;

  typedef enum logic [2:0] {OP_READ, OP_SIG, OP_SIG_HV, OP_PROGRAM, OP_ERASE, OP_RESET} fci_op_t;
  typedef enum logic [2:0] {ST_IDLE, ST_WR, ST_WRH, ST_RD, ST_DLY, ST_NEXT} fci_state_t;
  typedef enum logic [1:0] {A_WR, A_RD, A_JUMP, A_DONE} fci_act_t;
  typedef enum logic [4:0] {
    PH_VPP_ON, PH_SETREAD, PH_READ, PH_SIGCMD, PH_SIGREAD, PH_HVREAD,
    PH_PGM_CMD, PH_PGM_DATA, PH_PV_CMD, PH_PV_READ, PH_PV_CHECK, PH_PRE_NEXT,
    PH_ER_CMD1, PH_ER_CMD2, PH_EV_CMD, PH_EV_READ, PH_EV_CHECK,
    PH_RST1, PH_RST2, PH_FINISH, PH_FAIL
  } fci_phase_t;

endpackage

// [tb/fci_flash_model.sv]
// Purpose: Behavioural flash partner for the command host bench.
// Assumes: Pin events only; the part has no clock of its own.
// Notes: Pulses end at once, so the recovery check stands in for the stop timers.
`timescale 1ns/10ps
module fci_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5c, // Arbitrary value.
  parameter logic [7:0] PART_CODE = 8'h6d, // Arbitrary value.
  parameter int DEPTH = 4
) (
  input wire logic chipSelN,
  input wire logic outDriveN,
  input wire logic writeStrobeN,
  input wire logic programSupplyHigh,
  input wire logic addressBitNineHv,
  input wire logic [15:0] flashAddr,
  input wire logic [7:0] dqOut,
  input wire logic dqOeN,
  input wire logic stuckEn,
  input wire logic [15:0] stuckAddr,
  output logic [7:0] dqIn,
  output logic hostErr,
  output logic [7:0] pgmWrites
);
  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {M_RD, M_SIG, M_EV, M_PV} fci_fm_mode_t;
  logic [7:0] mem [0:65535];
  logic [15:0] addrLatch, verAddr;
  logic pgmArm, eraseArm, rstArm, drive, reErase;
  logic [7:0] rdByte, lastByte;
  fci_fm_mode_t mode;
  realtime lastWrite;

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'ha5;
    mode = M_RD;
    {pgmArm, eraseArm, rstArm, hostErr, reErase} = 5'h00;
    pgmWrites = 8'h00;
    lastByte = 8'h00;
    lastWrite = -1.0e9;
  end

  // Registered host pins all move on one edge, so look a little later.
  always @(negedge writeStrobeN) #1 begin
    if (!chipSelN) addrLatch = flashAddr;
    if (chipSelN || !outDriveN || !programSupplyHigh || dqOeN) hostErr = 1'b1;
  end

  always @(posedge writeStrobeN) begin : wr
    logic first;
    if (!chipSelN && programSupplyHigh) begin
      first = !pgmArm && !(eraseArm && dqOut == fci_pkg::CMD_ERASE) &&
              !(rstArm && dqOut == fci_pkg::CMD_RESET);
      if (pgmArm) begin
        if (!(stuckEn && addrLatch == stuckAddr)) mem[addrLatch] = dqOut;
        verAddr = addrLatch;
        pgmWrites = pgmWrites + 8'h01;
        reErase = 1'b0;
        lastWrite = $realtime;
        mode = M_RD;
      end else if (!first && eraseArm) begin
        // Only the first pulse after programming needs a pre-programmed array.
        if (!reErase) begin
          for (int i = 0; i < DEPTH; i++) if (mem[i] !== 8'h00) hostErr = 1'b1;
        end
        for (int i = 0; i < 65536; i++) begin
          if (!(stuckEn && i == stuckAddr)) mem[i] = 8'hff;
        end
        reErase = 1'b1;
        lastWrite = $realtime;
      end else if (!first) mode = M_RD;
      else case (dqOut)
        fci_pkg::CMD_SIG: mode = M_SIG;
        fci_pkg::CMD_EV: begin
          mode = M_EV;
          verAddr = addrLatch;
        end
        fci_pkg::CMD_PV: mode = M_PV;
        default: mode = M_RD;
      endcase
      pgmArm = first && dqOut == fci_pkg::CMD_PGM;
      eraseArm = first && dqOut == fci_pkg::CMD_ERASE;
      rstArm = first && dqOut == fci_pkg::CMD_RESET;
    end
  end

  // A read too soon after a pulse would see a part still busy.
  always @(negedge outDriveN) #1 if ($realtime - lastWrite < 6000.0) hostErr = 1'b1;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    if (addressBitNineHv) rdByte = flashAddr[0] ? PART_CODE : MAKER_CODE;
    else if (!programSupplyHigh) rdByte = mem[flashAddr];
    else case (mode)
      M_SIG: rdByte = flashAddr[0] ? PART_CODE : MAKER_CODE;
      M_EV: rdByte = mem[verAddr];
      M_PV: rdByte = mem[verAddr];
      default: rdByte = mem[flashAddr];
    endcase
  end

  assign drive = !chipSelN && !outDriveN && writeStrobeN;
  always @(drive or rdByte) begin
    if (drive) lastByte = rdByte;
    if (drive && !dqOeN) hostErr = 1'b1;
  end
  // A floating bus shows the inverse of the last byte, never a stale copy.
  assign dqIn = !dqOeN ? dqOut : drive ? rdByte : ~lastByte;
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the flash command host.
// Assumes: Shortened erase count and depth keep the run short.
// Notes: Expected bytes come from a shadow of the flash contents.
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] MAKER = 8'h5c; // Arbitrary value.
  localparam logic [7:0] PART = 8'h6d; // Arbitrary value.
  logic clk, nrst, reqValid, reqReady, rspValid, rspFail, stuckEn, hostErr, erased;
  logic chipSelN, outDriveN, writeStrobeN, programSupplyHigh, addressBitNineHv, dqOeN;
  fci_pkg::fci_op_t reqOp;
  logic [15:0] reqAddr, stuckAddr, flashAddr, lfsr;
  logic [7:0] reqData, rspData, dqIn, dqOut, pgmWrites;
  logic [7:0] shadow [int];
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;

  fci_host #(.ERASE_CYC(50), .DEPTH(4), .MAX_ERASE(3)) dut (.clk(clk), .nrst(nrst),
    .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .rspValid(rspValid), .rspFail(rspFail), .rspData(rspData),
    .chipSelN(chipSelN), .outDriveN(outDriveN), .writeStrobeN(writeStrobeN),
    .programSupplyHigh(programSupplyHigh), .addressBitNineHv(addressBitNineHv),
    .flashAddr(flashAddr), .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN));
  fci_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .DEPTH(4)) flash (
    .chipSelN(chipSelN), .outDriveN(outDriveN), .writeStrobeN(writeStrobeN),
    .programSupplyHigh(programSupplyHigh), .addressBitNineHv(addressBitNineHv),
    .flashAddr(flashAddr), .dqOut(dqOut), .dqOeN(dqOeN), .stuckEn(stuckEn),
    .stuckAddr(stuckAddr), .dqIn(dqIn), .hostErr(hostErr), .pgmWrites(pgmWrites));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    if (shadow.exists(a)) return shadow[a];
    return erased ? 8'hff : (a[7:0] ^ 8'ha5);
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Program and erase sequences are long, hence the generous bound.
  task automatic request(input fci_pkg::fci_op_t op, input logic [15:0] a,
                         input logic [7:0] d);
    int n;
    @(negedge clk);
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = a;
    reqData = d;
    do @(posedge clk); while (reqReady !== 1'b1);
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 60000) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, rspValid}, 8'h01, "completion");
    check({3'h0, chipSelN, outDriveN, writeStrobeN, dqOeN, programSupplyHigh}, 8'h1e, "release");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] a;
    logic [7:0] d, w0;
    nrst = 1'b0;
    reqValid = 1'b0;
    reqOp = fci_pkg::OP_READ;
    reqAddr = 16'h0000;
    reqData = 8'h00;
    stuckEn = 1'b0;
    stuckAddr = 16'h0000;
    erased = 1'b0;
    lfsr = 16'h911a;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    check({3'h0, chipSelN, outDriveN, writeStrobeN, dqOeN, programSupplyHigh}, 8'h1e, "idle");
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : lfsr;
      request(fci_pkg::OP_READ, a, lfsr[7:0]);
      check(rspData, exp_byte(a), "read");
    end
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      request(i < 2 ? fci_pkg::OP_SIG : fci_pkg::OP_SIG_HV, {lfsr[15:1], i[0]}, 8'h00);
      check(rspData, i[0] ? PART : MAKER, "signature");
    end
    for (int i = 0; i < 2; i++) begin
      lfsr = lfsr_next(lfsr);
      a = i ? lfsr : 16'hffff;
      d = lfsr[15:8];
      w0 = pgmWrites;
      request(fci_pkg::OP_PROGRAM, a, d);
      shadow[a] = d;
      check({7'h00, rspFail}, 8'h00, "program status");
      check(rspData, d, "program verify");
      check(pgmWrites - w0, 8'h01, "one pulse");
      request(fci_pkg::OP_READ, a, 8'h00);
      check(rspData, d, "read back");
    end
    lfsr = lfsr_next(lfsr);
    a = lfsr;
    stuckAddr = a;
    stuckEn = 1'b1;
    w0 = pgmWrites;
    request(fci_pkg::OP_PROGRAM, a, ~exp_byte(a));
    check({7'h00, rspFail}, 8'h01, "stuck byte");
    check(pgmWrites - w0, 8'h19, "attempts");
    stuckEn = 1'b0;
    request(fci_pkg::OP_PROGRAM, 16'h0002, 8'h00);
    stuckAddr = 16'h0002;
    stuckEn = 1'b1;
    request(fci_pkg::OP_ERASE, 16'h0000, 8'h00);
    check({7'h00, rspFail}, 8'h01, "erase gives up");
    check(rspData, 8'h00, "stuck erase verify");
    stuckEn = 1'b0;
    request(fci_pkg::OP_ERASE, 16'h0000, 8'h00);
    shadow.delete();
    erased = 1'b1;
    check({7'h00, rspFail}, 8'h00, "erase status");
    check(rspData, 8'hff, "erase verify");
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? 16'h0003 : lfsr;
      request(fci_pkg::OP_READ, a, 8'h00);
      check(rspData, exp_byte(a), "erased read");
    end
    request(fci_pkg::OP_RESET, 16'h0000, 8'h00);
    check({7'h00, rspFail}, 8'h00, "reset status");
    request(fci_pkg::OP_READ, 16'h0001, 8'h00);
    check(rspData, 8'hff, "read after reset");
    check({7'h00, hostErr}, 8'h00, "pin protocol");
    final_report;
  end
endmodule
